//--- wdrt_map.svh
// register map and constants of the watchdog reset timer
`ifndef WDRT_MAP_SVH
`define WDRT_MAP_SVH
`define WDRT_ADDR_WIDTH 12
`define WDRT_CTRL_COUNT_INDEX 12'h2EF
`define WDRT_CTRL_COUNT_ADDR (12'(`WDRT_CTRL_COUNT_INDEX * 4))
`define WDRT_CLEAR_BIT 3
`define WDRT_COUNT_MSB 2
`define WDRT_COUNT_RESET 3'h0
`define WDRT_CLK_HZ 250000000
`define WDRT_TICK_HZ 2
`define WDRT_TICK_CYCLES (`WDRT_CLK_HZ / `WDRT_TICK_HZ)
`endif

//--- wdrt_pkg.sv
// types of the watchdog reset timer
package wdrt_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } wdrt_apb_req_type;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } wdrt_apb_rsp_type;
   typedef enum logic [1:0] {
      WDRT_RUN  = 2'b01,
      WDRT_FIRE = 2'b10
   } wdrt_state_type;
endpackage : wdrt_pkg

//--- wdrt_sync.sv
// two-flop synchroniser for the 2 Hz tick level
`timescale 1ns/100ps
module wdrt_sync (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic din,
   output logic      dout
);
   logic stage1;
   logic next_stage1;
   logic next_dout;
   always_comb begin
      next_stage1 = nrst ? din : 1'b0;
      next_dout   = nrst ? stage1 : 1'b0;
   end
   always_ff @(posedge ref_clk) begin
      stage1 <= next_stage1;
      dout   <= next_dout;
   end
endmodule : wdrt_sync

//--- wdrt_top.sv
// watchdog reset timer with apb register access
// --------------------------------------------------------------
// Notes on behaviour
// - counter advances only on the 2 Hz tick from the low-speed oscillator
// - three-bit binary counter; overflow of its top bit raises initial reset
// - without a clear for 3.5 to 4 seconds, initial reset is raised
// - counting continues while the cpu is halted
// - writing 1 to bit 3 zeroes the counter; writing 0 does nothing
// - the clear bit always reads as 0
// - bits 2..0 read the counter, all zero after initial reset
// - build option removes the watchdog; then no reset ever fires
// --------------------------------------------------------------
//
// Register access over APB was decided locally.
`include "wdrt_map.svh"
`timescale 1ns/100ps
module wdrt_top
   import wdrt_pkg::*;
#(
   parameter bit WDRT_ENABLE = 1'b1
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        tick_2hz,
   input  wire logic        cpu_halted,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   output logic             initial_reset
);
   // --------------------------------------------------------------
   // tick capture
   // --------------------------------------------------------------
   wdrt_apb_req_type req;
   logic             tick_sync;
   logic             tick_prev;
   logic             tick_rise;
   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
   wdrt_sync u_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     (tick_2hz),
      .dout    (tick_sync)
   );
   assign tick_rise = tick_sync & ~tick_prev;
   // --------------------------------------------------------------
   // bus decode
   // --------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a);
      hit = (a == `WDRT_CTRL_COUNT_ADDR);
   endfunction : hit
   // halting stops the cpu, never this counter; cpu_halted is not consulted
   logic       access;
   logic       clear_wr;
   logic [2:0] count;
   logic [2:0] next_count;
   logic       next_reset;
   logic       next_ready;
   logic       next_err;
   logic [31:0] next_rdata;
   wdrt_state_type state;
   wdrt_state_type next_state;
   assign access   = req.psel & req.penable & ~pready;
   assign clear_wr = access & req.pwrite & hit(req.paddr) & req.pwdata[`WDRT_CLEAR_BIT];
   // --------------------------------------------------------------
   // counter and reset
   // --------------------------------------------------------------
   // the fire state lasts one cycle, so the reset pulse cannot stretch
   // a tick that lands in the fire cycle is lost; ticks are far apart
   always_comb begin
      next_count = count;
      next_state = state;
      next_reset = 1'b0;
      case (state)
         WDRT_RUN: begin
            if (clear_wr) begin
               next_count = `WDRT_COUNT_RESET;
            end else if (tick_rise) begin
               next_count = 3'(count + 3'h1);
               if (count == 3'h7 && WDRT_ENABLE) begin
                  next_state = WDRT_FIRE;
                  next_reset = 1'b1;
               end
            end
         end
         WDRT_FIRE: begin
            next_count = `WDRT_COUNT_RESET;
            next_state = WDRT_RUN;
         end
         default: begin
            next_count = `WDRT_COUNT_RESET;
            next_state = WDRT_RUN;
         end
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         count         <= `WDRT_COUNT_RESET;
         state         <= WDRT_RUN;
         initial_reset <= 1'b0;
         tick_prev     <= 1'b0;
      end else begin
         count         <= next_count;
         state         <= next_state;
         initial_reset <= next_reset;
         tick_prev     <= tick_sync;
      end
   end
   // --------------------------------------------------------------
   // register answer
   // --------------------------------------------------------------
   // one wait state: the answer is registered so every output leaves a flip-flop
   always_comb begin
      next_ready = access;
      next_err   = access & ~hit(req.paddr);
      next_rdata = 32'h0;
      if (access & ~req.pwrite & hit(req.paddr)) begin
         next_rdata = {29'h0, count};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         prdata        <= 32'h0;
      end else begin
         pready        <= next_ready;
         pslverr       <= next_err;
         prdata        <= next_rdata;
      end
   end
   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   sequence s_plain_tick;
      state == WDRT_RUN && tick_rise && !clear_wr;
   endsequence : s_plain_tick
   sequence s_top_tick;
      state == WDRT_RUN && tick_rise && !clear_wr && count == 3'h7;
   endsequence : s_top_tick
   sequence s_idle_write;
      state == WDRT_RUN && access && req.pwrite && hit(req.paddr) && !req.pwdata[`WDRT_CLEAR_BIT] && !tick_rise;
   endsequence : s_idle_write
   sequence s_count_read;
      access && !req.pwrite && hit(req.paddr);
   endsequence : s_count_read
   sequence s_fire_then_run;
      state == WDRT_FIRE ##1 state == WDRT_RUN;
   endsequence : s_fire_then_run
   a_clear_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
      clear_wr && state == WDRT_RUN |=> count == 3'h0)
      else $error("clear did not zero counter");
   a_tick_only: assert property (@(posedge ref_clk) disable iff (!nrst)
      !tick_rise && !clear_wr && state == WDRT_RUN |=> $stable(count))
      else $error("counter moved without tick");
   a_fire_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(initial_reset) |-> $past(count) == 3'h7 && $past(tick_rise))
      else $error("reset without overflow");
   a_fire_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
      initial_reset |=> !initial_reset)
      else $error("reset longer than one cycle");
   a_no_fire_off: assert property (@(posedge ref_clk) disable iff (!nrst)
      !WDRT_ENABLE |-> !initial_reset)
      else $error("disabled watchdog fired");
   a_read_strobe: assert property (@(posedge ref_clk) disable iff (!nrst)
      pready |-> prdata[`WDRT_CLEAR_BIT] == 1'b0)
      else $error("clear bit read as one");
   a_read_count: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_count_read |=> prdata[2:0] == $past(count))
      else $error("read data not counter");
   a_halt_counts: assert property (@(posedge ref_clk) disable iff (!nrst)
      cpu_halted && tick_rise && !clear_wr && state == WDRT_RUN |=> count == 3'($past(count) + 3'h1))
      else $error("counter stalled in halt");
   a_step_tick: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_plain_tick |=> count == 3'($past(count) + 3'h1))
      else $error("counter did not step on tick");
   a_wrap_fire: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_top_tick |=> initial_reset == WDRT_ENABLE && count == 3'h0)
      else $error("overflow handled wrongly");
   a_fire_back: assert property (@(posedge ref_clk) disable iff (!nrst)
      initial_reset |-> s_fire_then_run)
      else $error("fire state did not return");
   a_sync_delay: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(tick_2hz) |-> ##2 tick_rise)
      else $error("tick edge not seen in time");
   a_idle_write: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_idle_write |=> $stable(count))
      else $error("zero write moved counter");
   a_reset_zero: assert property (@(posedge ref_clk)
      !nrst |=> count == 3'h0 && !initial_reset && state == WDRT_RUN)
      else $error("reset did not clear counter");
   a_fire_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
      initial_reset |-> count == 3'h0)
      else $error("counter not zero at reset pulse");
   a_halt_fire: assert property (@(posedge ref_clk) disable iff (!nrst)
      cpu_halted && state == WDRT_RUN && tick_rise && !clear_wr && count == 3'h7 |=> initial_reset == WDRT_ENABLE)
      else $error("halt blocked reset");
   a_rise_single: assert property (@(posedge ref_clk) disable iff (!nrst)
      tick_rise |=> !tick_rise)
      else $error("tick edge longer than one cycle");
   a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
      pready |=> !pready)
      else $error("ready longer than one cycle");
   a_refuse_err: assert property (@(posedge ref_clk) disable iff (!nrst)
      access && !hit(req.paddr) |=> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_err_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == WDRT_RUN && access && req.pwrite && !hit(req.paddr) && !tick_rise |=> $stable(count))
      else $error("unmapped write moved counter");
   a_fire_spacing: assert property (@(posedge ref_clk) disable iff (!nrst)
      initial_reset |=> (!initial_reset) [*7])
      else $error("reset pulses too close");
   a_state_legal: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == WDRT_RUN || state == WDRT_FIRE)
      else $error("illegal state");
endmodule : wdrt_top

//--- wdrt_cpu_model.sv
// cpu core stand-in that counts initial reset pulses
`timescale 1ns/100ps
module wdrt_cpu_model (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       initial_reset,
   output logic [7:0]      reset_count
);
   // a pulse restarts the core; here it is only counted for the bench
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reset_count <= 8'h00;
      end else if (initial_reset) begin
         reset_count <= reset_count + 8'h01;
      end
   end
endmodule : wdrt_cpu_model

//--- tb_top.sv
// self-checking bench of the watchdog reset timer
`include "wdrt_map.svh"
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   import wdrt_pkg::*;
   logic ref_clk = 0, nrst = 0, tick_2hz = 0, cpu_halted = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, initial_reset;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        er;
   logic [7:0]  reset_count, off_count;
   logic        off_reset;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   always #2 ref_clk = ~ref_clk;
   wdrt_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .tick_2hz(tick_2hz), .cpu_halted(cpu_halted),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .initial_reset(initial_reset));
   wdrt_cpu_model u_cpu (.ref_clk(ref_clk), .nrst(nrst), .initial_reset(initial_reset),
      .reset_count(reset_count));
   // second copy built without the watchdog; it must never raise reset
   wdrt_top #(.WDRT_ENABLE(1'b0)) u_dut_off (.ref_clk(ref_clk), .nrst(nrst), .tick_2hz(tick_2hz),
      .cpu_halted(cpu_halted), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(), .pslverr(), .prdata(), .initial_reset(off_reset));
   wdrt_cpu_model u_cpu_off (.ref_clk(ref_clk), .nrst(nrst), .initial_reset(off_reset),
      .reset_count(off_count));
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // ceiling far above the few hundred cycles the scenarios need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         give_verdict;
      end
   end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task tick(input int n);
      repeat (n) begin
         @(posedge ref_clk) tick_2hz <= 1;
         repeat (4) @(posedge ref_clk);
         tick_2hz <= 0;
         repeat (4) @(posedge ref_clk);
      end
   endtask : tick
   task t_reset;
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(er, 1'b0)
   endtask : t_reset
   task t_count;
      tick(5);
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h5)
      apb(1, `WDRT_CTRL_COUNT_ADDR, 32'hFFFFFFF7);
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h5)
   endtask : t_count
   task t_clear;
      apb(1, `WDRT_CTRL_COUNT_ADDR, 32'h8);
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h0)
      tick(1);
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h1)
   endtask : t_clear
   task t_refuse;
      apb(1, 12'hBB8, 32'h8);
      `CHK(er, 1'b1)
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h1)
   endtask : t_refuse
   task t_midreset;
      tick(2);
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h3)
      nrst <= 0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1;
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h0)
   endtask : t_midreset
   task t_collide;
      tick(3);
      // pin rises two cycles early so its synchronised edge lands on the access edge of the clear write
      @(posedge ref_clk) tick_2hz <= 1;
      apb(1, `WDRT_CTRL_COUNT_ADDR, 32'h8);
      tick_2hz <= 0;
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h0)
   endtask : t_collide
   task t_overflow;
      cpu_halted <= 1;
      apb(1, `WDRT_CTRL_COUNT_ADDR, 32'h8);
      tick(7);
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h7)
      `CHK(reset_count, 8'h00)
      tick(1);
      `CHK(reset_count, 8'h01)
      `CHK(off_count, 8'h00)
      apb(0, `WDRT_CTRL_COUNT_ADDR, 32'h0);
      `CHK(rd, 32'h0)
   endtask : t_overflow
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1;
      t_reset;
      t_count;
      t_clear;
      t_refuse;
      t_midreset;
      t_overflow;
      t_collide;
      give_verdict;
   end
endmodule : tb_top
